// ==== rtl/bfsc_params.svh ====
// Constants for the binary frame stuffing codec.
`ifndef BFSC_PARAMS_SVH
`define BFSC_PARAMS_SVH
`define BFSC_ESCAPE       8'h80
`define BFSC_START        8'h81
`define BFSC_END          8'h82
`define BFSC_CTRL_TOP     8'h87
`define BFSC_LOW7         8'h7F
`define BFSC_HIGH_BIT     8'h80
`define BFSC_INDEX_ALL    8'hFF
`define BFSC_CLASS_SET    8'h01
`define BFSC_CLASS_QUERY  8'h02
`define BFSC_CLASS_SYSTEM 8'h03
`define BFSC_ACK_CODE     8'h10
`define BFSC_BUF_BYTES    132
`define BFSC_MAX_BYTES    8'd134
`define BFSC_MAX_PAYLOAD  8'd128
`define BFSC_BAUD         38400
`define BFSC_CLK_HZ       100000000
`define BFSC_CNT_W        8
`define BFSC_OFS_PLAIN    8'h03
`define BFSC_OFS_INDEXED  8'h04
`define BFSC_CODE_BYTES   8'd3
`define BFSC_SUB_POS      8'd2
`define BFSC_STUFF_FROM   8'h02
`define BFSC_FIRST_SLOT   8'h01
`endif

// ==== rtl/bfsc_pkg.sv ====
// Types shared by the binary frame stuffing codec.
package bfsc_pkg;
	// One byte with its stream markers.
	typedef struct packed {
		logic [7:0] data;
		logic       first;
		logic       last;
	} bfsc_byte_s;

	// Receive error causes.
	typedef struct packed {
		logic double_start;
		logic escape_in_code;
		logic bad_escape;
		logic ctrl_idle;
		logic too_long;
		logic bad_sum;
	} bfsc_err_s;

	typedef enum logic [2:0] {
		BFSC_TX_IDLE  = 3'b000,
		BFSC_TX_START = 3'b001,
		BFSC_TX_BODY  = 3'b011,
		BFSC_TX_ESC   = 3'b010,
		BFSC_TX_SUM   = 3'b110,
		BFSC_TX_SESC  = 3'b111,
		BFSC_TX_END   = 3'b101
	} bfsc_tx_e;
endpackage

// ==== rtl/bfsc_codec.sv ====
// Framer and deframer for the stuffed binary message protocol.
`timescale 1ns/1ps
`include "bfsc_params.svh"
module bfsc_codec (
	input  wire logic                 clk,
	input  wire logic                 rst,
	// Transmit message: group code first, payload, last marks final byte.
	input  wire bfsc_pkg::bfsc_byte_s tx_msg,
	input  wire logic                 tx_msg_valid,
	output logic                      tx_msg_ready,
	// Serial bytes toward the UART.
	output logic [7:0]                tx_ser_data,
	output logic                      tx_ser_valid,
	input  wire logic                 tx_ser_ready,
	// Serial bytes from the UART.
	input  wire logic [7:0]           rx_ser_data,
	input  wire logic                 rx_ser_valid,
	// Indexed code hint from the parser, read at the sub code.
	input  wire logic                 rx_indexed,
	// Delivered message bytes, group code first, after a good checksum.
	output bfsc_pkg::bfsc_byte_s      rx_msg,
	output logic                      rx_msg_valid,
	output logic [7:0]                rx_payload_ofs,
	output logic                      rx_frame_ok,
	output bfsc_pkg::bfsc_err_s       rx_err
);

	// True for the eight control characters. Escape, start and end are in use
	// today; the five above them are held back for later control duties, so
	// the stuffer already escapes them and the pre-parser flags them outside a frame. This
	// keeps an older receiver framing correctly when new control bytes appear.
	function automatic logic is_ctrl(input logic [7:0] b);
		is_ctrl = (b >= `BFSC_ESCAPE) && (b <= `BFSC_CTRL_TOP);
	endfunction

	// Transmit side. The state register walks the frame one serial byte at a
	// time; the running sum covers the start marker and every message byte, so
	// the checksum only has to fold in the end marker when it is sent.
	// tx_pos_reg counts message bytes taken so far and decides where stuffing
	// may begin: the two code bytes never fall in the control range.
	bfsc_pkg::bfsc_tx_e tx_state_reg;
	logic [7:0]         tx_sum_reg;
	logic [7:0]         tx_hold_reg;
	logic               tx_last_reg;
	logic               tx_ser_valid_reg;
	logic [7:0]         tx_ser_data_reg;
	logic [7:0]         tx_pos_reg;
	logic               tx_free;
	logic [7:0]         tx_cs;

	// The serial slot is free when nothing waits or the waiting byte leaves on
	// this edge; the message side is only ready while a body byte can move.
	assign tx_free      = !tx_ser_valid_reg || tx_ser_ready;
	assign tx_ser_valid = tx_ser_valid_reg;
	assign tx_ser_data  = tx_ser_data_reg;
	assign tx_cs        = 8'h00 - tx_sum_reg - `BFSC_END;
	assign tx_msg_ready = tx_free && (tx_state_reg == bfsc_pkg::BFSC_TX_BODY);

	// Framer: codes pass raw, payload and checksum are stuffed.
	// Acknowledgement ordering and report scheduling are the firmware's; this
	// framer only guarantees each frame goes out whole.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tx_state_reg     <= bfsc_pkg::BFSC_TX_IDLE;
			tx_sum_reg       <= 8'h00;
			tx_hold_reg      <= 8'h00;
			tx_last_reg      <= 1'b0;
			tx_ser_valid_reg <= 1'b0;
			tx_ser_data_reg  <= 8'h00;
			tx_pos_reg       <= 8'h00;
		end
		else
		begin
			if (tx_ser_ready)
				tx_ser_valid_reg <= 1'b0;
			case (tx_state_reg)
				// The first byte is only looked at here; it is taken later in the body.
				bfsc_pkg::BFSC_TX_IDLE:
					if (tx_msg_valid && tx_msg.first)
						tx_state_reg <= bfsc_pkg::BFSC_TX_START;
				// The start marker also seeds the running sum.
				bfsc_pkg::BFSC_TX_START:
					if (tx_free)
					begin
						tx_ser_data_reg  <= `BFSC_START;
						tx_ser_valid_reg <= 1'b1;
						tx_sum_reg       <= `BFSC_START;
						tx_pos_reg       <= 8'h00;
						tx_state_reg     <= bfsc_pkg::BFSC_TX_BODY;
					end
				// One message byte per free slot; a control value costs two slots,
				// so the caller sees ready drop while the second half goes out.
				bfsc_pkg::BFSC_TX_BODY:
					if (tx_free && tx_msg_valid)
					begin
						tx_sum_reg       <= tx_sum_reg + tx_msg.data;
						tx_last_reg      <= tx_msg.last;
						tx_pos_reg       <= tx_pos_reg + 8'h01;
						tx_ser_valid_reg <= 1'b1;
						// Code bytes are never control characters, so no stuffing.
						if (is_ctrl(tx_msg.data) && tx_pos_reg >= `BFSC_STUFF_FROM)
						begin
							tx_ser_data_reg <= `BFSC_ESCAPE;
							tx_hold_reg     <= tx_msg.data & `BFSC_LOW7;
							tx_state_reg    <= bfsc_pkg::BFSC_TX_ESC;
						end
						else
						begin
							tx_ser_data_reg <= tx_msg.data;
							if (tx_msg.last)
								tx_state_reg <= bfsc_pkg::BFSC_TX_SUM;
						end
					end
				// Second half of a stuffed body byte.
				bfsc_pkg::BFSC_TX_ESC:
					if (tx_free)
					begin
						tx_ser_data_reg  <= tx_hold_reg;
						tx_ser_valid_reg <= 1'b1;
						tx_state_reg     <= tx_last_reg ? bfsc_pkg::BFSC_TX_SUM
						                                : bfsc_pkg::BFSC_TX_BODY;
					end
				// The checksum is stuffed like a payload byte when it lands in range.
				bfsc_pkg::BFSC_TX_SUM:
					if (tx_free)
					begin
						tx_ser_valid_reg <= 1'b1;
						if (is_ctrl(tx_cs))
						begin
							tx_ser_data_reg <= `BFSC_ESCAPE;
							tx_state_reg    <= bfsc_pkg::BFSC_TX_SESC;
						end
						else
						begin
							tx_ser_data_reg <= tx_cs;
							tx_state_reg    <= bfsc_pkg::BFSC_TX_END;
						end
					end
				// Second half of a stuffed checksum.
				bfsc_pkg::BFSC_TX_SESC:
					if (tx_free)
					begin
						tx_ser_data_reg  <= tx_cs & `BFSC_LOW7;
						tx_ser_valid_reg <= 1'b1;
						tx_state_reg     <= bfsc_pkg::BFSC_TX_END;
					end
				// The end marker closes the frame and frees the framer for the next.
				bfsc_pkg::BFSC_TX_END:
					if (tx_free)
					begin
						tx_ser_data_reg  <= `BFSC_END;
						tx_ser_valid_reg <= 1'b1;
						tx_state_reg     <= bfsc_pkg::BFSC_TX_IDLE;
					end
				default:
					tx_state_reg <= bfsc_pkg::BFSC_TX_IDLE;
			endcase
		end
	end

	// Receive side: assembled bytes are buffered until the checksum agrees,
	// because data must not reach the parser from a frame that later fails.
	// Serial bytes come from an 8N1 UART at the link rate in this clock's
	// domain, one rx_ser_valid pulse per byte; at the link rate a byte takes
	// thousands of clocks, so the drain below finishes long before the next
	// byte can land.
	logic [7:0]  rx_buf [0:`BFSC_BUF_BYTES-1];
	logic        rx_open_reg;
	logic        rx_esc_reg;
	logic [7:0]  rx_cnt_reg;
	logic [7:0]  rx_sum_reg;
	logic [7:0]  rx_ofs_reg;
	logic        rx_drain_reg;
	logic [7:0]  rx_rd_reg;
	logic [7:0]  rx_len_reg;
	logic [7:0]  rx_mbyte;
	logic        rx_put;
	bfsc_pkg::bfsc_err_s rx_err_next;

	// Assembled byte from the current serial byte, and the error causes that
	// this serial byte would raise. Errors are judged before any state moves,
	// so the same cycle can both flag a fault and drop the frame.
	always_comb
	begin
		rx_mbyte    = rx_esc_reg ? (rx_ser_data | `BFSC_HIGH_BIT) : rx_ser_data;
		rx_put      = rx_ser_valid && rx_open_reg && !rx_drain_reg
		              && rx_ser_data != `BFSC_ESCAPE
		              && rx_ser_data != `BFSC_START && rx_ser_data != `BFSC_END;
		rx_err_next = '0;
		if (rx_ser_valid && !rx_drain_reg)
		begin
			if (rx_open_reg && rx_ser_data == `BFSC_START)
				rx_err_next.double_start = 1'b1;
			if (rx_open_reg && rx_ser_data == `BFSC_ESCAPE && rx_cnt_reg < `BFSC_CODE_BYTES)
				rx_err_next.escape_in_code = 1'b1;
			if (rx_open_reg && rx_esc_reg && !is_ctrl(rx_ser_data | `BFSC_HIGH_BIT))
				rx_err_next.bad_escape = 1'b1;
			if (!rx_open_reg && is_ctrl(rx_ser_data) && rx_ser_data != `BFSC_START)
				rx_err_next.ctrl_idle = 1'b1;
			// Slot 133 holds the 134th assembled byte, the start marker counted.
			if (rx_put && rx_cnt_reg >= `BFSC_MAX_BYTES - 8'd1)
				rx_err_next.too_long = 1'b1;
			if (rx_open_reg && rx_ser_data == `BFSC_END
			    && (rx_sum_reg + `BFSC_END) != 8'h00)
				rx_err_next.bad_sum = 1'b1;
		end
	end

	// Assembly state; an error drops the frame. A second start also reopens.
	// rx_cnt_reg is the buffer slot of the next assembled byte, so the start
	// marker sits in slot zero by implication and is never written. The sum
	// starts at the start marker and the end marker is added only in the check.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_open_reg <= 1'b0;
			rx_esc_reg  <= 1'b0;
			rx_cnt_reg  <= 8'h00;
			rx_sum_reg  <= 8'h00;
			rx_ofs_reg  <= 8'h00;
			rx_len_reg  <= 8'h00;
		end
		else if (rx_ser_valid && !rx_drain_reg)
		begin
			if (rx_ser_data == `BFSC_START)
			begin
				rx_open_reg <= 1'b1;
				rx_esc_reg  <= 1'b0;
				rx_cnt_reg  <= `BFSC_FIRST_SLOT;
				rx_sum_reg  <= `BFSC_START;
				rx_ofs_reg  <= `BFSC_OFS_PLAIN;
			end
			else if (rx_open_reg)
			begin
				if (rx_err_next != '0 || rx_ser_data == `BFSC_END)
				begin
					rx_open_reg <= 1'b0;
					rx_esc_reg  <= 1'b0;
					rx_len_reg  <= rx_cnt_reg - 8'd2;
				end
				else if (rx_ser_data == `BFSC_ESCAPE)
					rx_esc_reg <= 1'b1;
				else
				begin
					rx_esc_reg <= 1'b0;
					rx_cnt_reg <= rx_cnt_reg + 8'd1;
					rx_sum_reg <= rx_sum_reg + rx_mbyte;
					if (rx_cnt_reg == `BFSC_SUB_POS && rx_indexed)
						rx_ofs_reg <= `BFSC_OFS_INDEXED;
				end
			end
		end
	end

	// Buffer write of each assembled byte from slot 1 to slot 131. The buffer has
	// no reset: a slot is only read after this frame has written it.
	always_ff @(posedge clk)
	begin
		if (rx_put && rx_cnt_reg < `BFSC_BUF_BYTES)
			rx_buf[rx_cnt_reg] <= rx_mbyte;
	end

	// Delivery of a checked frame, codes through payload; serial input is
	// ignored while draining, so the host must pace frames apart. The checksum
	// slot is not delivered unless it is the frame's only byte, since it carries nothing for the parser once it
	// has agreed. The stop test uses at-or-past so that a frame with only one
	// byte before the end marker cannot wrap the read pointer into a long drain.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_drain_reg <= 1'b0;
			rx_rd_reg    <= 8'h00;
			rx_msg       <= '0;
			rx_msg_valid <= 1'b0;
			rx_frame_ok  <= 1'b0;
			rx_err       <= '0;
			rx_payload_ofs <= 8'h00;
		end
		else
		begin
			rx_err       <= rx_err_next;
			rx_frame_ok  <= 1'b0;
			rx_msg_valid <= 1'b0;
			if (rx_ser_valid && !rx_drain_reg && rx_open_reg
			    && rx_ser_data == `BFSC_END && rx_err_next == '0)
			begin
				rx_drain_reg   <= 1'b1;
				rx_rd_reg      <= `BFSC_FIRST_SLOT;
				rx_frame_ok    <= 1'b1;
				rx_payload_ofs <= rx_ofs_reg;
			end
			else if (rx_drain_reg)
			begin
				rx_msg.data  <= rx_buf[rx_rd_reg];
				rx_msg.first <= rx_rd_reg == `BFSC_FIRST_SLOT;
				rx_msg.last  <= rx_rd_reg >= rx_len_reg;
				rx_msg_valid <= 1'b1;
				rx_rd_reg    <= rx_rd_reg + `BFSC_FIRST_SLOT;
				if (rx_rd_reg >= rx_len_reg)
					rx_drain_reg <= 1'b0;
			end
		end
	end

endmodule // bfsc_codec

// ==== bench/bfsc_monitor.sv ====
// Port checker for the binary frame stuffing codec.
`timescale 1ns/1ps
module bfsc_monitor (
	input wire logic                 clk,
	input wire logic                 rst,
	input wire logic [7:0]           tx_ser_data,
	input wire logic                 tx_ser_valid,
	input wire logic                 tx_ser_ready,
	input wire logic [7:0]           rx_ser_data,
	input wire logic                 rx_ser_valid,
	input wire bfsc_pkg::bfsc_byte_s rx_msg,
	input wire logic                 rx_msg_valid,
	input wire logic [7:0]           rx_payload_ofs,
	input wire logic                 rx_frame_ok,
	input wire bfsc_pkg::bfsc_err_s  rx_err
);
	// One clock domain, so clocking and reset are given once.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_ser_hold: assert property (
		tx_ser_valid && !tx_ser_ready |=> tx_ser_valid && $stable(tx_ser_data))
		else $error("serial byte changed while stalled");
	chk_escape_pair: assert property (
		tx_ser_valid && tx_ser_ready && tx_ser_data == 8'h80 |=> tx_ser_valid && tx_ser_data <= 8'h07)
		else $error("escape not followed by low bits");
	chk_end_closes: assert property (
		rx_frame_ok |-> $past(rx_ser_valid) && $past(rx_ser_data) == 8'h82)
		else $error("frame accepted without end marker");
	chk_deliver_next: assert property (
		rx_frame_ok |=> rx_msg_valid && rx_msg.first)
		else $error("delivery did not follow good frame");
	chk_payload_ofs: assert property (
		rx_frame_ok |-> rx_payload_ofs == 8'h03 || rx_payload_ofs == 8'h04)
		else $error("payload offset out of range");
	chk_double_start: assert property (
		rx_err.double_start |-> $past(rx_ser_data) == 8'h81)
		else $error("double start without start byte");
	chk_code_escape: assert property (
		rx_err.escape_in_code |-> $past(rx_ser_data) == 8'h80)
		else $error("code escape error without escape");
	chk_bad_escape: assert property (
		rx_err.bad_escape |-> $past(rx_ser_data) > 8'h07)
		else $error("bad escape flagged on valid byte");
	chk_idle_ctrl: assert property (
		rx_err.ctrl_idle |-> $past(rx_ser_data) inside {[8'h80:8'h87]})
		else $error("idle error on plain byte");
	chk_sum_drop: assert property (
		rx_err.bad_sum |-> $past(rx_ser_data) == 8'h82 && !rx_msg_valid ##1 !rx_msg_valid [*2])
		else $error("bad frame delivered data");
	chk_last_ends: assert property (
		rx_msg_valid && !rx_msg.last |=> rx_msg_valid && !rx_msg.first)
		else $error("delivery stopped before the last byte");
endmodule // bfsc_monitor

bind bfsc_codec bfsc_monitor i_bfsc_monitor (
	.clk            (clk),
	.rst            (rst),
	.tx_ser_data    (tx_ser_data),
	.tx_ser_valid   (tx_ser_valid),
	.tx_ser_ready   (tx_ser_ready),
	.rx_ser_data    (rx_ser_data),
	.rx_ser_valid   (rx_ser_valid),
	.rx_msg         (rx_msg),
	.rx_msg_valid   (rx_msg_valid),
	.rx_payload_ofs (rx_payload_ofs),
	.rx_frame_ok    (rx_frame_ok),
	.rx_err         (rx_err)
);

// ==== bench/bfsc_host_model.sv ====
// Host side of the serial link: stalls transmit bytes and sends stuffed bytes.
`timescale 1ns/1ps
module bfsc_host_model (
	input  wire logic       clk,
	output logic            ser_ready,
	output logic [7:0]      ser_data,
	output logic            ser_valid
);
	// Stalls change at the falling edge, so the codec sees them settled.
	initial
	begin
		ser_data = 8'h00;
		ser_valid = 1'b0;
	end
	always @(negedge clk)
		ser_ready <= ($urandom % 4) != 0;
	// One byte as a one-cycle pulse; an idle line shows the inverse, not a stale copy.
	task automatic pulse(input logic [7:0] v);
		@(negedge clk);
		ser_data = v;
		ser_valid = 1'b1;
		@(negedge clk);
		ser_data = ~v;
		ser_valid = 1'b0;
	endtask
	// Escapes control values before sending when the position allows it.
	task automatic send(input logic [7:0] v, input logic st);
		if (st && v[7:3] == 5'h10)
		begin
			pulse(8'h80);
			v = v & 8'h7F;
		end
		pulse(v);
	endtask
endmodule // bfsc_host_model

// ==== bench/binary_frame_stuffing_codec_test.sv ====
// Self-checking bench for the binary frame stuffing codec.
`timescale 1ns/1ps
module binary_frame_stuffing_codec_test;
	logic                 clk;
	logic                 rst;
	bfsc_pkg::bfsc_byte_s tx_msg;
	logic                 tx_msg_valid;
	logic                 tx_msg_ready;
	logic [7:0]           tx_ser_data;
	logic                 tx_ser_valid;
	logic                 tx_ser_ready;
	logic [7:0]           rx_ser_data;
	logic                 rx_ser_valid;
	logic                 rx_indexed;
	bfsc_pkg::bfsc_byte_s rx_msg;
	logic                 rx_msg_valid;
	logic [7:0]           rx_payload_ofs;
	logic                 rx_frame_ok;
	bfsc_pkg::bfsc_err_s  rx_err;
	int                   n_mismatch;
	int                   total_checks;
	logic [7:0]           q_ser[$];
	logic [7:0]           q_msg[$];
	logic [7:0]           q_ofs[$];
	logic [7:0]           q_err[$];
	logic [7:0]           b[$];
	bfsc_codec i_bfsc_codec (
		.clk            (clk),
		.rst            (rst),
		.tx_msg         (tx_msg),
		.tx_msg_valid   (tx_msg_valid),
		.tx_msg_ready   (tx_msg_ready),
		.tx_ser_data    (tx_ser_data),
		.tx_ser_valid   (tx_ser_valid),
		.tx_ser_ready   (tx_ser_ready),
		.rx_ser_data    (rx_ser_data),
		.rx_ser_valid   (rx_ser_valid),
		.rx_indexed     (rx_indexed),
		.rx_msg         (rx_msg),
		.rx_msg_valid   (rx_msg_valid),
		.rx_payload_ofs (rx_payload_ofs),
		.rx_frame_ok    (rx_frame_ok),
		.rx_err         (rx_err)
	);
	bfsc_host_model i_host (
		.clk       (clk),
		.ser_ready (tx_ser_ready),
		.ser_data  (rx_ser_data),
		.ser_valid (rx_ser_valid)
	);
	// Free-running 100 MHz clock.
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Compares a result with the oldest note; a missing note fails as unknown.
	task automatic cmp(input string what, ref logic [7:0] q[$], input logic [7:0] seen);
		logic [7:0] exp;
		total_checks++;
		exp = (q.size() > 0) ? q.pop_front() : 8'hXX;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Leftover notes mean a result never came out.
	task automatic tally_and_finish;
		n_mismatch += q_ser.size() + q_msg.size() + q_ofs.size() + q_err.size();
		if (n_mismatch == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Notes a transmit byte, escaped when it lies in the control range.
	function automatic void note_ser(input logic [7:0] v, input logic st);
		if (st && v[7:3] == 5'h10)
		begin
			q_ser.push_back(8'h80);
			v = v & 8'h7F;
		end
		q_ser.push_back(v);
	endfunction
	// Hands one message to the framer and notes the serial bytes it must give.
	task automatic tx_frame(input logic [7:0] m[$]);
		logic [7:0] cs;
		cs = 8'h00 - 8'h81 - 8'h82;
		q_ser.push_back(8'h81);
		foreach (m[i])
		begin
			cs -= m[i];
			note_ser(m[i], i > 1);
		end
		note_ser(cs, 1'b1);
		q_ser.push_back(8'h82);
		@(negedge clk);
		foreach (m[i])
		begin
			tx_msg = '{m[i], i == 0, i == m.size() - 1};
			tx_msg_valid = 1'b1;
			// The byte is taken at the rising edge where ready is seen high.
			do
				@(posedge clk);
			while (!tx_msg_ready);
			@(negedge clk);
		end
		tx_msg_valid = 1'b0;
		wait (q_ser.size() == 0);
	endtask
	// Sends a host frame and notes its delivery, or a checksum error when spoiled.
	task automatic rx_frame(input logic [7:0] m[$], input logic ix, input logic bad);
		logic [7:0] cs;
		cs = 8'h00 - 8'h81 - 8'h82 + {7'h00, bad};
		@(negedge clk);
		rx_indexed = ix;
		i_host.send(8'h81, 1'b0);
		foreach (m[i])
		begin
			cs -= m[i];
			if (!bad)
				q_msg.push_back(m[i]);
			i_host.send(m[i], i > 1);
		end
		// The checksum slot is not handed on, so only the message bytes are noted.
		if (bad)
			q_err.push_back(8'h01);
		else
			q_ofs.push_back(8'h03 + {7'h00, ix});
		i_host.send(cs, 1'b1);
		i_host.send(8'h82, 1'b0);
		repeat (2 * m.size() + 8) @(negedge clk);
	endtask
	// Watches the outputs and checks each result against its note.
	always @(posedge clk)
	begin
		if (!rst && tx_ser_valid && tx_ser_ready)
			cmp("tx_ser_data", q_ser, tx_ser_data);
		if (!rst && rx_msg_valid)
			cmp("rx_msg", q_msg, rx_msg.data);
		if (!rst && rx_frame_ok)
			cmp("rx_payload_ofs", q_ofs, rx_payload_ofs);
		if (!rst && rx_err != '0)
			cmp("rx_err", q_err, {2'b00, rx_err});
	end
	// Cuts a hang short well beyond the expected run length.
	initial
	begin
		repeat (30000) @(posedge clk);
		n_mismatch++;
		tally_and_finish();
	end
	// Main sequence.
	initial
	begin
		n_mismatch = 0;
		total_checks = 0;
		rst = 1'b1;
		tx_msg = '0;
		tx_msg_valid = 1'b0;
		rx_indexed = 1'b0;
		void'($urandom(90));
		repeat (8) @(negedge clk);
		rst = 1'b0;
		for (int k = 0; k < 8; k++)
		begin
			b = '{8'h10, 8'h01, 8'h80 + k[7:0], 8'($urandom)};
			tx_frame(b);
		end
		for (int k = 0; k < 4; k++)
		begin
			b = '{8'h24, 8'h01, 8'($urandom), 8'h80 + k[7:0], 8'h87 - k[7:0]};
			rx_frame(b, k[0], k[1]);
		end
		rx_frame('{8'h01, 8'h24, 8'h01, 8'h03}, 1'b0, 1'b0);
		rx_frame('{8'h02, 8'h14, 8'h01, 8'hFF}, 1'b1, 1'b0);
		q_err.push_back(8'h20);
		i_host.pulse(8'h81);
		i_host.pulse(8'h10);
		rx_frame('{8'h10, 8'h02, 8'h85}, 1'b0, 1'b0);
		q_err.push_back(8'h10);
		i_host.pulse(8'h81);
		i_host.pulse(8'h80);
		q_err.push_back(8'h08);
		b = '{8'h81, 8'h10, 8'h01, 8'h80, 8'h10};
		foreach (b[i])
			i_host.pulse(b[i]);
		q_err.push_back(8'h02);
		b = '{8'h81, 8'h10, 8'h01};
		foreach (b[i])
			i_host.pulse(b[i]);
		repeat (131) i_host.pulse(8'h11);
		i_host.pulse(8'h41);
		b = '{8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h82, 8'h80};
		foreach (b[i])
		begin
			q_err.push_back(8'h04);
			i_host.pulse(b[i]);
		end
		repeat (10) @(negedge clk);
		tally_and_finish();
	end
endmodule // binary_frame_stuffing_codec_test
